// *** hdl/tcs_pkg.sv ***
// Purpose: shared constants for the statistics access and status registers
// Assumes: APB word addressing, byte address = 4 * register index
// Notes: register widths are 16 bits, held in the low half of the word
package tcs_pkg;

   localparam int ADDR_W = 16;
   localparam int DATA_W = 32;
   localparam int REG_W = 16;
   localparam int IDX_W = 12;
   localparam int MAX_LINKS = 16;
   localparam int STROBE_DIV_DEFAULT = 8000;

   // register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_GEN_STATUS = 12'h40E;
   localparam logic [IDX_W-1:0] IDX_CMD = 12'h40F;
   localparam logic [IDX_W-1:0] IDX_OVF_BASE = 12'h410;
   localparam logic [IDX_W-1:0] IDX_CNT_BYTE3 = 12'h430;
   localparam logic [IDX_W-1:0] IDX_CNT_SEL = 12'h433;

   // general status bits
   localparam int GS_LINK_TRANSMIT_CLOCK_LOSS = 3;
   localparam int GS_LINK_RECEIVE_CLOCK_LOSS = 2;
   localparam int GS_TXFIFO_OVF = 1;
   localparam int GS_CELLRAM_FULL = 0;
   localparam logic [REG_W-1:0] GS_RESET = 16'h0000;

   // command register fields
   localparam int CMD_OP_LSB = 0;
   localparam int CMD_DIR = 2;
   localparam int CMD_IEN = 3;
   localparam int CMD_RSV4 = 4;
   localparam int CMD_TOGGLE = 6;
   localparam int CMD_DONE = 7;
   localparam int CMD_MODE_LSB = 8;
   localparam int CMD_SWLATCH = 10;
   localparam int CMD_RSV11 = 11;
   localparam logic [REG_W-1:0] CMD_RESET = 16'h0080;

   // per-link overflow bits
   localparam int OV_RXFIFO = 12;
   localparam int OV_U_ALL = 11;
   localparam int OV_U_IDLE = 10;
   localparam int OV_U_UNAS = 9;
   localparam int OV_U_HEC = 8;
   localparam int OV_TX_ALL = 7;
   localparam int OV_TX_IDLE = 6;
   localparam int OV_RX_ALL = 3;
   localparam int OV_RX_IDLE = 2;
   localparam int OV_RX_HEC = 1;
   localparam logic [REG_W-1:0] OVF_RESET = 16'h0000;

   localparam logic [7:0] BYTE_RESET = 8'h00;

   typedef enum logic [1:0] {OP_CLEAR, OP_VALUE, OP_IEN, OP_NONE} tcs_op_e;
   typedef enum logic [1:0] {LM_OFF, LM_EACH, LM_DIV, LM_SOFT} tcs_latch_e;

endpackage

// *** hdl/tcs_snap_trig.sv ***
// Purpose: counter snapshot trigger generator
// Assumes: strobe input synchronous to clk_in
// Notes: one-cycle snapshot pulse per selected trigger
`timescale 1ns/10ps
module tcs_snap_trig
#(
   parameter int DIV = tcs_pkg::STROBE_DIV_DEFAULT
)
(
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic strobe_in,
   input wire tcs_pkg::tcs_latch_e mode_in,
   input wire logic sw_trig_in,
   output logic snapshot_out
);
   import tcs_pkg::*;

   localparam int CNT_W = $clog2(DIV);
   localparam logic [CNT_W-1:0] LAST = CNT_W'(DIV - 1);

   logic strobe_prev_r;
   logic [CNT_W-1:0] div_r;
   logic rise;

   assign rise = strobe_in & ~strobe_prev_r;

   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
         strobe_prev_r <= 1'b0;
      else
         strobe_prev_r <= strobe_in;
   end

   // divider restarts whenever the divided mode is left
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
         div_r <= '0;
      else if (mode_in != LM_DIV)
         div_r <= '0;
      else if (rise)
         div_r <= (div_r == LAST) ? '0 : div_r + 1'b1;
   end

   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
         snapshot_out <= 1'b0;
      else
         snapshot_out <= (mode_in == LM_EACH && rise) ||
                         (mode_in == LM_DIV && rise && div_r == LAST) ||
                         // soft request already checked against new mode
                         sw_trig_in;
   end

endmodule

// *** hdl/tcs_stats_regs.sv ***
// Purpose: statistics access command and status flag registers on APB
// Assumes: event inputs are one-cycle or level pulses synchronous to clk_in
// Notes: counters live outside; this block drives their access handshake
// Functional notes
// - bit 3 latches UTOPIA transmit clock loss
// - bit 2 latches UTOPIA receive clock loss
// - bit 1 flags any transmit FIFO overflow
// - bit 0 latches cell memory full
// - bits 9:8 select snapshot trigger mode
// - soft mode snapshots on bit 10 rise
// - bit 7 reads transfer done, host writes zero
// - bit 6 toggles on every host write
// - bit 2 sets transfer direction
// - bits 1:0 clear, value or enable transfer
// - bit 3 carries the interrupt enable value
// - command register resets to 0080
// - bit 5 reserved, reads undefined
// - bit 12 latches receive FIFO overflow
// - bits 11..8 latch UTOPIA counter overflows
// - bits 7,6 latch transmit TDM overflows
// - bit 3 latches receive TDM all overflow
// - bits 2,1 latch receive idle, HEC overflows
// - data register holds counter top byte
`timescale 1ns/10ps
module tcs_stats_regs
#(
   parameter int NUM_LINKS = tcs_pkg::MAX_LINKS,
   parameter int SEL_W = 8,
   parameter int STROBE_DIV = tcs_pkg::STROBE_DIV_DEFAULT
)
(
   input wire logic clk_in,
   input wire logic rstn_in,
   // apb slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [tcs_pkg::ADDR_W-1:0] paddr_in,
   input wire logic [tcs_pkg::DATA_W-1:0] pwdata_in,
   input wire logic [3:0] pstrb_in,
   output logic [tcs_pkg::DATA_W-1:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // general status events
   input wire logic utopia_tx_clk_loss_in,
   input wire logic utopia_rx_clk_loss_in,
   input wire logic [NUM_LINKS-1:0] tx_fifo_ovf_in,
   input wire logic cell_ram_full_in,
   // per-link overflow events
   input wire logic [NUM_LINKS-1:0] rx_fifo_ovf_in,
   input wire logic [NUM_LINKS-1:0] utopia_all_ovf_in,
   input wire logic [NUM_LINKS-1:0] utopia_idle_ovf_in,
   input wire logic [NUM_LINKS-1:0] utopia_unas_ovf_in,
   input wire logic [NUM_LINKS-1:0] utopia_hec_ovf_in,
   input wire logic [NUM_LINKS-1:0] tx_all_ovf_in,
   input wire logic [NUM_LINKS-1:0] tx_idle_ovf_in,
   input wire logic [NUM_LINKS-1:0] rx_all_ovf_in,
   input wire logic [NUM_LINKS-1:0] rx_idle_ovf_in,
   input wire logic [NUM_LINKS-1:0] rx_hec_ovf_in,
   // snapshot
   input wire logic snapshot_strobe_input_in,
   output logic snapshot_out,
   // counter store access
   output logic cnt_req_out,
   output tcs_pkg::tcs_op_e cnt_op_out,
   output logic cnt_dir_out,
   output logic cnt_ien_out,
   output logic [SEL_W-1:0] cnt_sel_out,
   output logic [7:0] cnt_wbyte_out,
   input wire logic cnt_done_in,
   input wire logic [7:0] cnt_rbyte_in
);
   import tcs_pkg::*;

   typedef enum logic {AC_IDLE, AC_BUSY} tcs_acc_e;

   // sticky flag update: a set in the clear cycle wins
   function automatic logic [REG_W-1:0] flag_next
   (
      input logic [REG_W-1:0] cur,
      input logic [REG_W-1:0] set,
      input logic [REG_W-1:0] clr
   );
      flag_next = (cur & ~clr) | set;
   endfunction

   logic [IDX_W-1:0] idx;
   logic setup;
   logic wr;
   logic [REG_W-1:0] wdata;
   logic [REG_W-1:0] wmask;
   logic [REG_W-1:0] wclr;
   logic wr_cmd;
   logic issue;
   logic sw_trig;
   tcs_latch_e mode_new;

   logic [REG_W-1:0] gs_r;
   logic [REG_W-1:0] gs_set;
   logic [REG_W-1:0] ovf_r [NUM_LINKS];

   tcs_op_e op_r;
   logic dir_r;
   logic ien_r;
   logic rsv4_r;
   logic rsv11_r;
   logic toggle_r;
   tcs_latch_e mode_r;
   logic swlatch_r;
   tcs_acc_e acc_r;
   logic [7:0] wr_byte_r;
   logic [7:0] rd_byte_r;
   logic [SEL_W-1:0] sel_r;

   logic [REG_W-1:0] rd_word;
   logic rd_err;
   logic [DATA_W-1:0] prdata_r;
   logic pslverr_r;

   // apb decode: zero wait state, data prepared in the setup cycle
   assign idx = paddr_in[IDX_W+1:2];
   assign setup = psel_in & ~penable_in;
   assign wr = psel_in & penable_in & pwrite_in;
   assign wdata = pwdata_in[REG_W-1:0];
   assign wmask = {{8{pstrb_in[1]}}, {8{pstrb_in[0]}}};
   assign wclr = wmask & ~wdata;
   assign pready_out = 1'b1;
   assign prdata_out = prdata_r;
   assign pslverr_out = pslverr_r & psel_in & penable_in;

   assign wr_cmd = wr && idx == IDX_CMD && paddr_in[1:0] == 2'b00 &&
                   acc_r == AC_IDLE;
   assign mode_new = pstrb_in[1] ?
                     tcs_latch_e'(wdata[CMD_MODE_LSB +: 2]) : mode_r;
   // snapshot on a written 0 to 1 of bit 10 in soft mode
   assign sw_trig = wr_cmd && pstrb_in[1] && wdata[CMD_SWLATCH] &&
                    !swlatch_r && mode_new == LM_SOFT;
   assign issue = wr_cmd && pstrb_in[0] &&
                  tcs_op_e'(wdata[CMD_OP_LSB +: 2]) != OP_NONE;

   // general status events
   always_comb
   begin
      gs_set = '0;
      gs_set[GS_LINK_TRANSMIT_CLOCK_LOSS] = utopia_tx_clk_loss_in;
      gs_set[GS_LINK_RECEIVE_CLOCK_LOSS] = utopia_rx_clk_loss_in;
      gs_set[GS_TXFIFO_OVF] = |tx_fifo_ovf_in;
      gs_set[GS_CELLRAM_FULL] = cell_ram_full_in;
   end

   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
         gs_r <= GS_RESET;
      else if (wr && idx == IDX_GEN_STATUS && paddr_in[1:0] == 2'b00)
         gs_r <= flag_next(gs_r, gs_set, wclr);
      else
         gs_r <= flag_next(gs_r, gs_set, '0);
   end

   // per-link overflow flags; both link clocks must run upstream
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         for (int i = 0; i < NUM_LINKS; i++)
            ovf_r[i] <= OVF_RESET;
      end
      else
      begin
         for (int i = 0; i < NUM_LINKS; i++)
         begin
            logic [REG_W-1:0] set;
            logic [REG_W-1:0] clr;
            set = '0;
            set[OV_RXFIFO] = rx_fifo_ovf_in[i];
            set[OV_U_ALL] = utopia_all_ovf_in[i];
            set[OV_U_IDLE] = utopia_idle_ovf_in[i];
            set[OV_U_UNAS] = utopia_unas_ovf_in[i];
            set[OV_U_HEC] = utopia_hec_ovf_in[i];
            set[OV_TX_ALL] = tx_all_ovf_in[i];
            set[OV_TX_IDLE] = tx_idle_ovf_in[i];
            set[OV_RX_ALL] = rx_all_ovf_in[i];
            set[OV_RX_IDLE] = rx_idle_ovf_in[i];
            set[OV_RX_HEC] = rx_hec_ovf_in[i];
            clr = '0;
            if (wr && paddr_in[1:0] == 2'b00 &&
                idx == IDX_OVF_BASE + IDX_W'(i))
               clr = wclr;
            ovf_r[i] <= flag_next(ovf_r[i], set, clr);
         end
      end
   end

   // command fields; refused while an access runs
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         op_r <= OP_CLEAR;
         dir_r <= 1'b0;
         ien_r <= 1'b0;
         rsv4_r <= 1'b0;
      end
      else if (wr_cmd && pstrb_in[0])
      begin
         op_r <= tcs_op_e'(wdata[CMD_OP_LSB +: 2]);
         dir_r <= wdata[CMD_DIR];
         ien_r <= wdata[CMD_IEN];
         rsv4_r <= wdata[CMD_RSV4];
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         mode_r <= LM_OFF;
         swlatch_r <= 1'b0;
         rsv11_r <= 1'b0;
      end
      else if (wr_cmd && pstrb_in[1])
      begin
         mode_r <= mode_new;
         swlatch_r <= wdata[CMD_SWLATCH];
         rsv11_r <= wdata[CMD_RSV11];
      end
   end

   // toggles on any completed write, written value ignored
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
         toggle_r <= 1'b0;
      else if (wr)
         toggle_r <= ~toggle_r;
   end

   // counter access handshake
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
         acc_r <= AC_IDLE;
      else
      begin
         unique case (acc_r)
            AC_IDLE:
               if (issue)
                  acc_r <= AC_BUSY;
            AC_BUSY:
               if (cnt_done_in)
                  acc_r <= AC_IDLE;
         endcase
      end
   end

   assign cnt_req_out = (acc_r == AC_BUSY);
   assign cnt_op_out = op_r;
   assign cnt_dir_out = dir_r;
   assign cnt_ien_out = ien_r;
   assign cnt_sel_out = sel_r;
   assign cnt_wbyte_out = wr_byte_r;

   // top byte data: write side held for the store, read side captured
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
         wr_byte_r <= BYTE_RESET;
      else if (wr && idx == IDX_CNT_BYTE3 && paddr_in[1:0] == 2'b00 &&
               pstrb_in[0])
         wr_byte_r <= wdata[7:0];
   end

   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
         rd_byte_r <= BYTE_RESET;
      else if (acc_r == AC_BUSY && cnt_done_in && op_r == OP_VALUE &&
               dir_r)
         rd_byte_r <= cnt_rbyte_in;
   end

   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
         sel_r <= '0;
      else if (wr && idx == IDX_CNT_SEL && paddr_in[1:0] == 2'b00 &&
               acc_r == AC_IDLE)
      begin
         for (int b = 0; b < SEL_W && b < REG_W; b++)
            if (wmask[b])
               sel_r[b] <= wdata[b];
      end
   end

   // read mux
   always_comb
   begin
      rd_word = '0;
      rd_err = 1'b0;
      if (paddr_in[1:0] != 2'b00)
         rd_err = 1'b1;
      else if (idx == IDX_GEN_STATUS)
         rd_word = gs_r;
      else if (idx == IDX_CMD)
      begin
         rd_word[CMD_OP_LSB +: 2] = op_r;
         rd_word[CMD_DIR] = dir_r;
         rd_word[CMD_IEN] = ien_r;
         rd_word[CMD_RSV4] = rsv4_r;
         rd_word[CMD_TOGGLE] = toggle_r;
         rd_word[CMD_DONE] = (acc_r == AC_IDLE);
         rd_word[CMD_MODE_LSB +: 2] = mode_r;
         rd_word[CMD_SWLATCH] = swlatch_r;
         rd_word[CMD_RSV11] = rsv11_r;
         // bit 5 is undefined to software; drive zero
      end
      else if (idx == IDX_CNT_BYTE3)
         rd_word[7:0] = rd_byte_r;
      else if (idx == IDX_CNT_SEL)
      begin
         for (int b = 0; b < SEL_W && b < REG_W; b++)
            rd_word[b] = sel_r[b];
      end
      else
      begin
         rd_err = 1'b1;
         for (int i = 0; i < NUM_LINKS; i++)
            if (idx == IDX_OVF_BASE + IDX_W'(i))
            begin
               rd_word = ovf_r[i];
               rd_err = 1'b0;
            end
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         prdata_r <= '0;
         pslverr_r <= 1'b0;
      end
      else if (setup)
      begin
         prdata_r <= pwrite_in ? '0 : {{(DATA_W-REG_W){1'b0}}, rd_word};
         pslverr_r <= rd_err;
      end
   end

   tcs_snap_trig
   #(
      .DIV(STROBE_DIV)
   )
   u_snap
   (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .strobe_in(snapshot_strobe_input_in),
      .mode_in(mode_r),
      .sw_trig_in(sw_trig),
      .snapshot_out(snapshot_out)
   );

endmodule

// *** testbench/tcs_cnt_store_model.sv ***
// Purpose: behavioural counter store behind the access handshake
// Assumes: one op per request, done raised lat_in + 1 cycles after the request
// Notes: read byte toggles when not being answered
`timescale 1ns/10ps
module tcs_cnt_store_model
(
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic [3:0] lat_in,
   input wire logic cnt_req_in,
   input wire tcs_pkg::tcs_op_e cnt_op_in,
   input wire logic cnt_dir_in,
   input wire logic cnt_ien_in,
   input wire logic [7:0] cnt_sel_in,
   input wire logic [7:0] cnt_wbyte_in,
   output logic cnt_done_out,
   output logic [7:0] cnt_rbyte_out
);
   import tcs_pkg::*;
   logic [7:0] mem [256];
   logic ien_r [256];
   logic [3:0] wait_r;
   logic fire;
   assign fire = cnt_req_in && !cnt_done_out && wait_r >= lat_in;
   always_ff @(posedge clk_in or negedge rstn_in)
      if (!rstn_in)
      begin
         cnt_done_out <= 1'b0;
         cnt_rbyte_out <= 8'hA5;
         wait_r <= 4'h0;
      end
      else
      begin
         cnt_done_out <= fire;
         cnt_rbyte_out <= fire ? mem[cnt_sel_in] : ~cnt_rbyte_out;
         wait_r <= (cnt_req_in && !fire) ? wait_r + 4'h1 : 4'h0;
      end
   always_ff @(posedge clk_in)
      if (fire && cnt_op_in == OP_CLEAR)
         foreach (mem[i])
            mem[i] <= 8'h00;
      else if (fire && cnt_op_in == OP_VALUE && !cnt_dir_in)
         mem[cnt_sel_in] <= cnt_wbyte_in;
      else if (fire && cnt_op_in == OP_IEN && !cnt_dir_in)
         ien_r[cnt_sel_in] <= cnt_ien_in;
endmodule

// *** testbench/tcs_stats_regs_assertions.sv ***
// Purpose: port checks for the stats register block
// Assumes: command at byte 0x103C, status at 0x1038
// Notes: a snapshot must follow a strobe rise or command write
`timescale 1ns/10ps
module tcs_stats_checker
(
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [15:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [3:0] pstrb_in,
   input wire logic [31:0] prdata_out,
   input wire logic pready_out,
   input wire logic pslverr_out,
   input wire logic snapshot_strobe_input_in,
   input wire logic snapshot_out,
   input wire logic cnt_req_out,
   input wire logic cnt_done_in
);
   logic acc;
   logic cmd_wr;
   logic [2:0] age_r;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   assign acc = psel_in && penable_in;
   assign cmd_wr = acc && pwrite_in && paddr_in == 16'h103C;
   // cycles since the last snapshot cause
   always_ff @(posedge clk_in or negedge rstn_in)
      if (!rstn_in)
         age_r <= 3'h7;
      else if (cmd_wr || (snapshot_strobe_input_in &&
               !$past(snapshot_strobe_input_in)))
         age_r <= 3'h0;
      else if (age_r != 3'h7)
         age_r <= age_r + 3'h1;
   a_ready_always: assert property (pready_out)
      else $error("pready low");
   a_req_start: assert property (cmd_wr && pstrb_in[0] &&
      pwdata_in[1:0] != 2'h3 && !cnt_req_out |=> cnt_req_out)
      else $error("access not started");
   a_req_hold: assert property (cnt_req_out && !cnt_done_in
      |=> cnt_req_out) else $error("access dropped early");
   a_req_end: assert property (cnt_req_out && cnt_done_in
      |=> !cnt_req_out) else $error("access not ended");
   a_snap_cause: assert property (snapshot_out |-> age_r <= 3'h3)
      else $error("snapshot without cause");
   a_snap_single: assert property (snapshot_out |=> !snapshot_out)
      else $error("snapshot too long");
   a_err_misalign: assert property (acc && paddr_in[1:0] != 2'h0
      |-> pslverr_out) else $error("misaligned not refused");
   a_cmd_fixed: assert property (acc && !pwrite_in &&
      paddr_in == 16'h103C |-> prdata_out[15:12] == 4'h0 && !prdata_out[5])
      else $error("command unused bits set");
   a_gs_unused: assert property (acc && !pwrite_in &&
      paddr_in == 16'h1038 |-> prdata_out[31:4] == 28'h0)
      else $error("status unused bits set");
   cover property (cnt_req_out && cnt_done_in);
   cover property (snapshot_out);
   cover property (acc && pslverr_out);
endmodule

// *** testbench/test_tc_stats_counter_access_status.sv ***
// Purpose: self-checking bench for the stats register block
// Assumes: counter store answers after a bench-set latency
// Notes: strobe divider shortened to four rises
`timescale 1ns/10ps
module test_tc_stats_counter_access_status;
   import tcs_pkg::*;
   logic clk_in, rstn_in, psel, pen, pwr, slv, strobe, done, req;
   logic dir, ien, snap, rdy, er;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb, lat, gs_ev;
   logic [15:0] ev [10];
   logic [7:0] rbyte, sel, wbyte;
   tcs_op_e op;
   int err_count, checked, nwr, snaps, s0;
   int bp [10] = '{12, 11, 10, 9, 8, 7, 6, 3, 2, 1};
   tcs_stats_regs #(.STROBE_DIV(4)) tcs_stats_regs_inst (.clk_in(clk_in),
      .rstn_in(rstn_in), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
      .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb),
      .prdata_out(prdata), .pready_out(rdy), .pslverr_out(slv),
      .utopia_tx_clk_loss_in(gs_ev[3]), .utopia_rx_clk_loss_in(gs_ev[2]),
      .tx_fifo_ovf_in({gs_ev[1], 15'h0000}), .cell_ram_full_in(gs_ev[0]),
      .rx_fifo_ovf_in(ev[0]), .utopia_all_ovf_in(ev[1]),
      .utopia_idle_ovf_in(ev[2]), .utopia_unas_ovf_in(ev[3]),
      .utopia_hec_ovf_in(ev[4]), .tx_all_ovf_in(ev[5]),
      .tx_idle_ovf_in(ev[6]), .rx_all_ovf_in(ev[7]),
      .rx_idle_ovf_in(ev[8]), .rx_hec_ovf_in(ev[9]),
      .snapshot_strobe_input_in(strobe), .snapshot_out(snap),
      .cnt_req_out(req), .cnt_op_out(op), .cnt_dir_out(dir),
      .cnt_ien_out(ien), .cnt_sel_out(sel), .cnt_wbyte_out(wbyte),
      .cnt_done_in(done), .cnt_rbyte_in(rbyte));
   tcs_cnt_store_model tcs_cnt_store_model_inst (.clk_in(clk_in),
      .rstn_in(rstn_in), .lat_in(lat), .cnt_req_in(req), .cnt_op_in(op),
      .cnt_dir_in(dir), .cnt_ien_in(ien), .cnt_sel_in(sel),
      .cnt_wbyte_in(wbyte), .cnt_done_out(done), .cnt_rbyte_out(rbyte));
   initial
   begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end
   always @(posedge clk_in)
      snaps += (snap === 1'b1);
   task automatic complete_run(input bit hang);
      err_count += hang;
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e)
      begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // one apb transfer, held until pready is sampled high
   task automatic xfer(input logic w, input logic [15:0] a,
      input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk_in);
      pen <= 1'b1;
      do
      begin
         @(posedge clk_in);
         n++;
      end
      while (rdy !== 1'b1 && n < 50);
      if (n >= 50)
         complete_run(1'b1);
      rd = prdata;
      er = slv;
      nwr += w;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk_in);
   endtask
   task automatic cmd(input logic [31:0] d);
      int n;
      n = 0;
      xfer(1'b1, 16'h103C, d, 4'h3);
      do
      begin
         xfer(1'b0, 16'h103C, 32'h0, 4'h0);
         n++;
      end
      while (rd[7] !== 1'b1 && n < 20);
      if (n >= 20)
         complete_run(1'b1);
   endtask
   task automatic rises(input int n);
      repeat (n)
      begin
         strobe <= 1'b1;
         repeat (2) @(posedge clk_in);
         strobe <= 1'b0;
         repeat (2) @(posedge clk_in);
      end
      repeat (4) @(posedge clk_in);
   endtask
   initial
   begin
      {psel, pen, pwr, strobe, rstn_in} = '0;
      {paddr, pwdata, pstrb, lat, gs_ev} = '0;
      foreach (ev[i])
         ev[i] = '0;
      {err_count, checked, nwr, snaps} = '0;
      repeat (20) @(posedge clk_in);
      rstn_in <= 1'b1;
      xfer(1'b0, 16'h103C, 32'h0, 4'h0);
      chk(rd, 32'h80);
      xfer(1'b0, 16'h1038, 32'h0, 4'h0);
      chk(rd, 32'h0);
      $display("reset values done");
      gs_ev <= 4'hF;
      @(posedge clk_in);
      gs_ev <= 4'h0;
      xfer(1'b1, 16'h1038, 32'h0, 4'h2);
      xfer(1'b1, 16'h1038, 32'hE, 4'h1);
      xfer(1'b0, 16'h1038, 32'h0, 4'h0);
      chk(rd, 32'hE);
      xfer(1'b1, 16'h1038, 32'h0, 4'h1);
      xfer(1'b0, 16'h1038, 32'h0, 4'h0);
      chk(rd, 32'h0);
      $display("status flags done");
      for (int i = 0; i < 10; i++)
      begin
         ev[i][i + 6] <= 1'b1;
         @(posedge clk_in);
         ev[i][i + 6] <= 1'b0;
         xfer(1'b1, 16'h1058 + 16'(i * 4), 32'hFFFF, 4'h3);
         xfer(1'b0, 16'h1058 + 16'(i * 4), 32'h0, 4'h0);
         chk(rd, 32'h1 << bp[i]);
         xfer(1'b1, 16'h1058 + 16'(i * 4), 32'h0, 4'h3);
         xfer(1'b0, 16'h1058 + 16'(i * 4), 32'h0, 4'h0);
         chk(rd, 32'h0);
      end
      $display("link flags done");
      xfer(1'b1, 16'h10CC, 32'h2A, 4'h1);
      xfer(1'b1, 16'h10C0, 32'h5C, 4'h1);
      lat <= 4'h9;
      xfer(1'b1, 16'h103C, 32'h1, 4'h3);
      xfer(1'b0, 16'h103C, 32'h0, 4'h0);
      chk(rd & 32'hC0, 32'(nwr[0]) << 6);
      cmd(32'h0);
      cmd(32'h1);
      chk(32'(tcs_cnt_store_model_inst.mem[8'h2A]), 32'h5C);
      lat <= 4'h0;
      xfer(1'b1, 16'h10C0, 32'h0, 4'h1);
      cmd(32'h5);
      xfer(1'b0, 16'h10C0, 32'h0, 4'h0);
      chk(rd, 32'h5C);
      cmd(32'hA);
      chk(32'(tcs_cnt_store_model_inst.ien_r[8'h2A]), 32'h1);
      cmd(32'h0);
      cmd(32'h5);
      xfer(1'b0, 16'h10C0, 32'h0, 4'h0);
      chk(rd, 32'h0);
      cmd(32'h3);
      chk(rd, 32'h83 | (32'(nwr[0]) << 6));
      $display("counter access done");
      s0 = snaps;
      rises(4);
      chk(32'(snaps - s0), 32'h0);
      cmd(32'h103);
      s0 = snaps;
      rises(4);
      chk(32'(snaps - s0), 32'h4);
      cmd(32'h203);
      s0 = snaps;
      rises(8);
      chk(32'(snaps - s0), 32'h2);
      s0 = snaps;
      cmd(32'h703);
      cmd(32'h703);
      cmd(32'h303);
      cmd(32'h703);
      chk(32'(snaps - s0), 32'h2);
      $display("snapshot modes done");
      xfer(1'b0, 16'h1100, 32'h0, 4'h0);
      chk({31'h0, er}, 32'h1);
      chk(rd, 32'h0);
      xfer(1'b1, 16'h103D, 32'h0, 4'hF);
      chk({31'h0, er}, 32'h1);
      xfer(1'b0, 16'h103C, 32'h0, 4'h0);
      chk(rd, 32'h783 | (32'(nwr[0]) << 6));
      $display("refused access done");
      complete_run(1'b0);
   end
endmodule
bind tcs_stats_regs tcs_stats_checker tcs_stats_checker_inst (.clk_in,
   .rstn_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
   .pstrb_in, .prdata_out, .pready_out, .pslverr_out,
   .snapshot_strobe_input_in, .snapshot_out, .cnt_req_out, .cnt_done_in);
